// ==== rtl/vic_pkg.sv ====
// constants, register map and carrier types of the vectored interrupt controller
// assumes one 200 MHz clock shared with the bus, the cpu sequencer and the event sources
package vic_pkg;
  localparam int PC_W = 13;
  localparam int NUM_SRC = 7;
  localparam int NUM_GRP = 4;
  localparam int FLAG_OFS = 4;
  // byte offsets on the register bus
  localparam logic [5:0] OFS_EDGE = 6'h00;
  localparam logic [5:0] OFS_CTRL0 = 6'h04;
  localparam logic [5:0] OFS_CTRL1 = 6'h08;
  localparam logic [5:0] OFS_CTRL2 = 6'h0C;
  localparam logic [5:0] OFS_GRP0 = 6'h10;
  localparam logic [5:0] OFS_STACK = 6'h20;
  localparam logic [7:0] RST_REG = 8'h00;
  // implemented bits of each register
  localparam logic [7:0] MASK_EDGE = 8'h0F;
  localparam logic [7:0] MASK_CTRL0 = 8'h7F;
  localparam logic [7:0] MASK_CTRL1 = 8'h99;
  localparam logic [7:0] MASK_CTRL2 = 8'h33;
  localparam logic [NUM_GRP-1:0][7:0] MASK_GRP = {8'h33, 8'hBB, 8'hFF, 8'h33};
  // control register 0
  localparam int GIE_BIT = 0;
  localparam int EXT0_EN_BIT = 1;
  localparam int EXT1_EN_BIT = 2;
  localparam int G0_EN_BIT = 3;
  localparam int EXT0_FLAG_BIT = 4;
  localparam int EXT1_FLAG_BIT = 5;
  localparam int G0_FLAG_BIT = 6;
  // control register 1
  localparam int ADC_EN_BIT = 0;
  localparam int G1_EN_BIT = 3;
  localparam int ADC_FLAG_BIT = 4;
  localparam int G1_FLAG_BIT = 7;
  // control register 2
  localparam int G2_EN_BIT = 0;
  localparam int G3_EN_BIT = 1;
  localparam int G2_FLAG_BIT = 4;
  localparam int G3_FLAG_BIT = 5;
  // stack status register
  localparam int STK_FULL_BIT = 7;
  // source numbering used by the priority and vector tables
  localparam logic [2:0] SRC_EXT0 = 3'h0;
  localparam logic [2:0] SRC_EXT1 = 3'h1;
  localparam logic [2:0] SRC_ADC = 3'h2;
  localparam logic [2:0] SRC_GRP0 = 3'h3;
  localparam logic [NUM_SRC*3-1:0] DEF_PRIO = 21'h1AC688;
  localparam logic [NUM_SRC*PC_W-1:0] DEF_VECTORS =
    {13'h001C, 13'h0018, 13'h0014, 13'h0010, 13'h000C, 13'h0008, 13'h0004};

  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } vic_edge_type;

  // member event lanes line up with the enable bits of each group register
  typedef struct packed {
    logic adc_done;
    logic [NUM_GRP-1:0][3:0] grp_evt;
  } vic_event_type;

  typedef struct packed {
    logic boundary;
    logic ret;
    logic [PC_W-1:0] next_pc;
  } vic_cpu_in_type;

  typedef struct packed {
    logic pc_load;
    logic irq_taken;
    logic [PC_W-1:0] pc_target;
    logic stack_full;
    logic wake;
  } vic_cpu_out_type;
endpackage

// ==== rtl/vic_top.sv ====
// vectored interrupt controller: flags, enables, groups, priority, stack and wake
// assumes avalon-mm master on the same clock and a cpu that flags instruction boundaries
//
// How it works
// - source trigger sets its request flag
// - flag vectors only when its enable set
// - global enable clear blocks every interrupt
// - accept pushes next pc, loads vector
// - return pops saved pc and resumes
// - accepting clears global enable automatically
// - flags still latch while globally blocked
// - full stack blocks acknowledge until pop
// - newly set flag wakes sleep or idle
// - pin flag set on selected edge type
// - pin works only with its enable set
// - servicing pin clears its flag too
// - adc flag set on done, cleared serviced
// - four groups gather the member sources
// - enabled member set raises group flag unless an enabled member already pending, group vectors
// - service clears group flag, members stay
// - first member register layout, all zero reset
// - second member register, bits 6,2 zero
// - third member register, unused bits zero
// - edge code: off, rise, fall, both
// - global enable bit 0 of control 0
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
module vic_top import vic_pkg::*; #(
  parameter int STACK_DEPTH = 8,
  parameter logic [NUM_SRC*3-1:0] PRIO_ORDER = DEF_PRIO,
  parameter logic [NUM_SRC*PC_W-1:0] VECTORS = DEF_VECTORS
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] ext_irq_pin,
  input wire vic_event_type src_event,
  input wire vic_cpu_in_type cpu_in,
  output vic_cpu_out_type cpu_out
);
  localparam int SP_W = $clog2(STACK_DEPTH + 1);

  typedef struct packed {
    logic [7:0] edge_sel;
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [NUM_GRP-1:0][7:0] grp;
    logic [NUM_GRP-1:0] grp_live;
    logic [1:0] pin_prev;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
    logic [SP_W-1:0] sp;
    logic waitreq;
    logic [7:0] rdata;
    vic_cpu_out_type cpu;
  } vic_state_type;

  vic_state_type st;
  vic_state_type next_st;
  logic [1:0] rst_sync;
  logic rst_n;
  logic [NUM_SRC-1:0] src_flag;
  logic [NUM_SRC-1:0] src_en;
  logic stack_full;
  logic [PC_W-1:0] top_entry;

  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic now);
    logic rise;
    logic fall;
    rise = now & ~prev;
    fall = prev & ~now;
    case (vic_edge_type'(sel))
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign src_flag = {st.ctrl2[G3_FLAG_BIT], st.ctrl2[G2_FLAG_BIT], st.ctrl1[G1_FLAG_BIT],
                     st.ctrl0[G0_FLAG_BIT], st.ctrl1[ADC_FLAG_BIT], st.ctrl0[EXT1_FLAG_BIT],
                     st.ctrl0[EXT0_FLAG_BIT]};
  assign src_en = {st.ctrl2[G3_EN_BIT], st.ctrl2[G2_EN_BIT], st.ctrl1[G1_EN_BIT],
                   st.ctrl0[G0_EN_BIT], st.ctrl1[ADC_EN_BIT], st.ctrl0[EXT1_EN_BIT],
                   st.ctrl0[EXT0_EN_BIT]};
  assign stack_full = st.sp == SP_W'(STACK_DEPTH);
  assign top_entry = st.stack[SP_W'(st.sp - 1'b1)];

  always_comb begin
    logic [NUM_SRC-1:0] pend;
    logic take;
    logic found;
    logic [2:0] pick;
    logic [2:0] cand;
    logic wake;
    logic [1:0] hit;
    logic [3:0] live;
    logic [7:0] wd;
    pend = '0;
    take = 1'b0;
    found = 1'b0;
    pick = 3'h0;
    cand = 3'h0;
    wake = 1'b0;
    hit = 2'b00;
    live = '0;
    wd = avs_writedata[7:0];
    next_st = st;
    next_st.cpu.pc_load = 1'b0;
    next_st.cpu.irq_taken = 1'b0;
    next_st.cpu.wake = 1'b0;
    // bus slave: one wait cycle, then the answer
    next_st.waitreq = !((avs_read || avs_write) && st.waitreq);
    case (avs_address)
      OFS_EDGE: next_st.rdata = st.edge_sel;
      OFS_CTRL0: next_st.rdata = st.ctrl0;
      OFS_CTRL1: next_st.rdata = st.ctrl1;
      OFS_CTRL2: next_st.rdata = st.ctrl2;
      OFS_GRP0: next_st.rdata = st.grp[0];
      OFS_GRP0 + 6'h04: next_st.rdata = st.grp[1];
      OFS_GRP0 + 6'h08: next_st.rdata = st.grp[2];
      OFS_GRP0 + 6'h0C: next_st.rdata = st.grp[3];
      OFS_STACK: next_st.rdata = {stack_full, 7'(st.sp)};
      default: next_st.rdata = 8'h00;
    endcase
    if (avs_write && !st.waitreq && avs_byteenable[0]) begin
      case (avs_address)
        OFS_EDGE: next_st.edge_sel = wd & MASK_EDGE;
        OFS_CTRL0: next_st.ctrl0 = wd & MASK_CTRL0;
        OFS_CTRL1: next_st.ctrl1 = wd & MASK_CTRL1;
        OFS_CTRL2: next_st.ctrl2 = wd & MASK_CTRL2;
        OFS_GRP0: next_st.grp[0] = wd & MASK_GRP[0];
        OFS_GRP0 + 6'h04: next_st.grp[1] = wd & MASK_GRP[1];
        OFS_GRP0 + 6'h08: next_st.grp[2] = wd & MASK_GRP[2];
        OFS_GRP0 + 6'h0C: next_st.grp[3] = wd & MASK_GRP[3];
        default: next_st.rdata = next_st.rdata;
      endcase
    end
    // acceptance and priority pick
    pend = src_flag & src_en;
    for (int r = NUM_SRC - 1; r >= 0; r--) begin
      cand = PRIO_ORDER[r*3 +: 3];
      if (pend[cand]) begin
        found = 1'b1;
        pick = cand;
      end
    end
    take = found && st.ctrl0[GIE_BIT] && !stack_full && cpu_in.boundary && !cpu_in.ret;
    if (cpu_in.ret && st.sp != '0) begin
      next_st.sp = SP_W'(st.sp - 1'b1);
      next_st.cpu.pc_target = top_entry;
      next_st.cpu.pc_load = 1'b1;
    end else if (take) begin
      next_st.stack[st.sp[SP_W-1:0]] = cpu_in.next_pc;
      next_st.sp = SP_W'(st.sp + 1'b1);
      next_st.cpu.pc_target = VECTORS[pick*PC_W +: PC_W];
      next_st.cpu.pc_load = 1'b1;
      next_st.cpu.irq_taken = 1'b1;
      next_st.ctrl0[GIE_BIT] = 1'b0;
      case (pick)
        SRC_EXT0: next_st.ctrl0[EXT0_FLAG_BIT] = 1'b0;
        SRC_EXT1: next_st.ctrl0[EXT1_FLAG_BIT] = 1'b0;
        SRC_ADC: next_st.ctrl1[ADC_FLAG_BIT] = 1'b0;
        SRC_GRP0: next_st.ctrl0[G0_FLAG_BIT] = 1'b0;
        SRC_GRP0 + 3'h1: next_st.ctrl1[G1_FLAG_BIT] = 1'b0;
        SRC_GRP0 + 3'h2: next_st.ctrl2[G2_FLAG_BIT] = 1'b0;
        default: next_st.ctrl2[G3_FLAG_BIT] = 1'b0;
      endcase
    end
    // hardware sets come last so a set wins over any clear
    next_st.pin_prev = ext_irq_pin;
    for (int p = 0; p < 2; p++) begin
      hit[p] = st.ctrl0[EXT0_EN_BIT + p] &&
               edge_hit(st.edge_sel[p*2 +: 2], st.pin_prev[p], ext_irq_pin[p]);
      if (hit[p]) begin
        wake = wake | !st.ctrl0[EXT0_FLAG_BIT + p];
        next_st.ctrl0[EXT0_FLAG_BIT + p] = 1'b1;
      end
    end
    if (src_event.adc_done) begin
      wake = wake | !st.ctrl1[ADC_FLAG_BIT];
      next_st.ctrl1[ADC_FLAG_BIT] = 1'b1;
    end
    for (int g = 0; g < NUM_GRP; g++) begin
      for (int k = 0; k < 4; k++) begin
        if (src_event.grp_evt[g][k] && MASK_GRP[g][k]) begin
          wake = wake | !st.grp[g][k + FLAG_OFS];
          next_st.grp[g][k + FLAG_OFS] = 1'b1;
        end
      end
      live[g] = |(next_st.grp[g][7:4] & next_st.grp[g][3:0]);
    end
    next_st.grp_live = live;
    if (live[0] && !st.grp_live[0]) begin
      wake = wake | !st.ctrl0[G0_FLAG_BIT];
      next_st.ctrl0[G0_FLAG_BIT] = 1'b1;
    end
    if (live[1] && !st.grp_live[1]) begin
      wake = wake | !st.ctrl1[G1_FLAG_BIT];
      next_st.ctrl1[G1_FLAG_BIT] = 1'b1;
    end
    if (live[2] && !st.grp_live[2]) begin
      wake = wake | !st.ctrl2[G2_FLAG_BIT];
      next_st.ctrl2[G2_FLAG_BIT] = 1'b1;
    end
    if (live[3] && !st.grp_live[3]) begin
      wake = wake | !st.ctrl2[G3_FLAG_BIT];
      next_st.ctrl2[G3_FLAG_BIT] = 1'b1;
    end
    next_st.cpu.wake = wake;
    next_st.cpu.stack_full = next_st.sp == SP_W'(STACK_DEPTH);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.edge_sel <= RST_REG;
      st.waitreq <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata = {24'h000000, st.rdata};
  assign avs_waitrequest = st.waitreq;
  assign cpu_out = st.cpu;

  // checks
  chk_gie_cleared: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cpu_out.irq_taken |-> !st.ctrl0[GIE_BIT])
    else $error("global enable still set after accept");
  chk_gie_blocks: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !st.ctrl0[GIE_BIT] |=> !cpu_out.irq_taken)
    else $error("interrupt taken while globally disabled");
  chk_full_blocks: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stack_full |=> !cpu_out.irq_taken)
    else $error("interrupt taken with full stack");
  chk_push_vector: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cpu_out.irq_taken |-> st.sp == SP_W'($past(st.sp) + 1'b1) && cpu_out.pc_load
      && top_entry == $past(cpu_in.next_pc))
    else $error("accept did not push the next pc");
  chk_pop_resume: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cpu_in.ret && st.sp != '0 |=> cpu_out.pc_load && cpu_out.pc_target == $past(top_entry)
      && !cpu_out.irq_taken)
    else $error("return did not resume saved pc");
  chk_enable_gates: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cpu_out.irq_taken |-> $past(src_flag & src_en) != '0)
    else $error("interrupt without enabled flag");
  chk_adc_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    src_event.adc_done |=> st.ctrl1[ADC_FLAG_BIT])
    else $error("adc flag not set on done");
  chk_wake_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    src_event.adc_done && !st.ctrl1[ADC_FLAG_BIT] |=> cpu_out.wake)
    else $error("new flag did not wake");
  chk_members_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cpu_out.irq_taken && !$past(avs_write) |->
      ($past(st.grp[1][7:4]) & ~st.grp[1][7:4]) == 4'h0)
    else $error("service cleared a member flag");
  chk_rise_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.ctrl0[EXT0_EN_BIT] && st.edge_sel[1:0] == 2'b01 && $rose(ext_irq_pin[0])
      |=> st.ctrl0[EXT0_FLAG_BIT])
    else $error("rising edge missed on pin 0");
  chk_bus_answer: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  chk_bus_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without a request");

  // accept and return
  chk_taken_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cpu_out.irq_taken |=> !cpu_out.irq_taken)
    else $error("second accept right after the first");
  chk_ret_no_take: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cpu_in.ret |=> !cpu_out.irq_taken)
    else $error("accept during a return");
  chk_full_output: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cpu_out.stack_full == (st.sp == SP_W'(STACK_DEPTH)))
    else $error("stack full output wrong");
  chk_sp_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.sp <= SP_W'(STACK_DEPTH))
    else $error("stack pointer beyond depth");
  chk_gie_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == OFS_CTRL0
      |=> cpu_out.irq_taken || st.ctrl0[GIE_BIT] == $past(avs_writedata[0]))
    else $error("global enable write lost");

  // service clears
  chk_ext0_service: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cpu_out.irq_taken && cpu_out.pc_target == VECTORS[PC_W-1:0] && !$past(avs_write)
      && !$past(ext_irq_pin[0] ^ st.pin_prev[0]) |-> !st.ctrl0[EXT0_FLAG_BIT])
    else $error("pin 0 flag kept after service");
  chk_adc_service: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cpu_out.irq_taken && cpu_out.pc_target == VECTORS[SRC_ADC*PC_W +: PC_W]
      && !$past(avs_write) && !$past(src_event.adc_done) |-> !st.ctrl1[ADC_FLAG_BIT])
    else $error("adc flag kept after service");
  chk_grp_service: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cpu_out.irq_taken && cpu_out.pc_target == VECTORS[SRC_GRP0*PC_W +: PC_W]
      && !$past(avs_write) && !(st.grp_live[0] && !$past(st.grp_live[0]))
      |-> !st.ctrl0[G0_FLAG_BIT])
    else $error("group 0 flag kept after service");
  chk_flag_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !st.ctrl0[GIE_BIT] && st.ctrl1[ADC_FLAG_BIT] && !avs_write
      |=> st.ctrl1[ADC_FLAG_BIT])
    else $error("blocked request flag lost");

  // external pins
  chk_pin0_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !st.ctrl0[EXT0_EN_BIT] && !st.ctrl0[EXT0_FLAG_BIT] && !avs_write
      |=> !st.ctrl0[EXT0_FLAG_BIT])
    else $error("disabled pin 0 raised its flag");
  chk_pin1_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !st.ctrl0[EXT1_EN_BIT] && !st.ctrl0[EXT1_FLAG_BIT] && !avs_write
      |=> !st.ctrl0[EXT1_FLAG_BIT])
    else $error("disabled pin 1 raised its flag");
  chk_edge_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.edge_sel[1:0] == 2'b00 && !st.ctrl0[EXT0_FLAG_BIT] && !avs_write
      |=> !st.ctrl0[EXT0_FLAG_BIT])
    else $error("pin 0 flag set with edges off");
  chk_fall_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.ctrl0[EXT0_EN_BIT] && st.edge_sel[1:0] == 2'b10 && $fell(ext_irq_pin[0])
      |=> st.ctrl0[EXT0_FLAG_BIT])
    else $error("falling edge missed on pin 0");
  chk_both_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.ctrl0[EXT0_EN_BIT] && st.edge_sel[1:0] == 2'b11
      && ($rose(ext_irq_pin[0]) || $fell(ext_irq_pin[0])) |=> st.ctrl0[EXT0_FLAG_BIT])
    else $error("edge missed on pin 0 in both mode");
  chk_wake_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.ctrl0[EXT0_EN_BIT] && st.edge_sel[1:0] == 2'b01 && $rose(ext_irq_pin[0])
      && !st.ctrl0[EXT0_FLAG_BIT] |=> cpu_out.wake)
    else $error("pin flag did not wake");

  // groups
  chk_grp0_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.grp_live[0] && !$past(st.grp_live[0]) |-> st.ctrl0[G0_FLAG_BIT])
    else $error("group 0 flag not raised");
  chk_grp1_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.grp_live[1] && !$past(st.grp_live[1]) |-> st.ctrl1[G1_FLAG_BIT])
    else $error("group 1 flag not raised");
  chk_grp2_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.grp_live[2] && !$past(st.grp_live[2]) |-> st.ctrl2[G2_FLAG_BIT])
    else $error("group 2 flag not raised");
  chk_grp3_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.grp_live[3] && !$past(st.grp_live[3]) |-> st.ctrl2[G3_FLAG_BIT])
    else $error("group 3 flag not raised");
  chk_member_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.grp_live[1] == |(st.grp[1][7:4] & st.grp[1][3:0]))
    else $error("group 1 live without enabled member");

  // unimplemented bits
  chk_grp2_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st.grp[2] & ~MASK_GRP[2]) == 8'h00)
    else $error("reserved bit set in second member register");
  chk_grp3_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st.grp[3] & ~MASK_GRP[3]) == 8'h00)
    else $error("reserved bit set in third member register");
  chk_ctrl_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st.ctrl0 & ~MASK_CTRL0) == 8'h00 && (st.ctrl1 & ~MASK_CTRL1) == 8'h00
      && (st.ctrl2 & ~MASK_CTRL2) == 8'h00)
    else $error("reserved control bit set");
  chk_edge_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st.edge_sel & ~MASK_EDGE) == 8'h00)
    else $error("reserved edge select bit set");
endmodule // vic_top

// ==== tb/vic_cpu_model.sv ====
// cpu sequencer model: holds the pc, follows pc loads, offers instruction boundaries
// assumes the controller's cpu_out and a bench that pulses ret_req for one cycle
`timescale 1ns/100ps
module vic_cpu_model import vic_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic ret_req,
  input wire vic_cpu_out_type cpu_out,
  output vic_cpu_in_type cpu_in
);
  logic [PC_W-1:0] pc;
  logic phase;
  logic bnd;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pc <= 13'h0100;
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
      if (cpu_out.pc_load)
        pc <= cpu_out.pc_target;
    end
  end
  // no boundary while a return or a branch is in flight; slow mode offers every other cycle
  assign bnd = ~ret_req & ~cpu_out.pc_load & (slow ? phase : 1'b1);
  assign cpu_in = {bnd, ret_req, pc};
endmodule // vic_cpu_model

// ==== tb/vic_top_tb.sv ====
// self-checking bench for the interrupt controller with a cpu model
// assumes one 200 MHz clock; expected results queue up and a monitor retires them
`timescale 1ns/100ps
module vic_top_tb import vic_pkg::*;;
  localparam logic [3:0][5:0] GA = {OFS_CTRL2, OFS_CTRL2, OFS_CTRL1, OFS_CTRL0};
  localparam logic [3:0][7:0] GV = {8'h02, 8'h01, 8'h08, 8'h08};
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] ext_irq_pin = 2'b00;
  vic_event_type src_event = '0;
  vic_cpu_in_type cpu_in;
  vic_cpu_out_type cpu_out;
  logic slow = 1'b0;
  logic ret_req = 1'b0;
  logic [31:0] lfsr = 32'hA43D;
  logic [7:0] r;
  logic [31:0] exp_rd[$];
  logic [13:0] exp_pc[$];
  int error_cnt = 0;
  int checks = 0;
  int wake_cnt = 0;
  int w0;
  always #2.5 ref_clk = ~ref_clk;

  vic_top #(.STACK_DEPTH(2)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_irq_pin(ext_irq_pin), .src_event(src_event),
    .cpu_in(cpu_in), .cpu_out(cpu_out));
  vic_cpu_model cpu (.ref_clk(ref_clk), .reset_n(reset_n), .slow(slow), .ret_req(ret_req),
    .cpu_out(cpu_out), .cpu_in(cpu_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("BAD %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [13:0] vec(input int s);
    return {1'b1, DEF_VECTORS[s*PC_W +: PC_W]};
  endfunction
  task automatic bus(input logic [5:0] a, input logic wr, input logic [7:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= (rnd() & 32'hFFFFFF00) | {24'h0, d};
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_rd.push_back({24'h0, e});
    bus(a, 1'b0, 8'h00);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic evt(input vic_event_type e);
    src_event <= e;
    @(posedge ref_clk);
    src_event <= '0;
    idle(3);
  endtask
  task automatic ret_pulse();
    ret_req <= 1'b1;
    @(posedge ref_clk);
    ret_req <= 1'b0;
    idle(5);
  endtask
  task automatic final_report();
    if (error_cnt == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // monitor retires the oldest note whenever a result appears
  always @(posedge ref_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      check(avs_readdata, exp_rd.size() > 0 ? exp_rd.pop_front() : 'x);
    if (cpu_out.pc_load === 1'b1)
      check({18'h0, cpu_out.irq_taken, cpu_out.pc_target},
        exp_pc.size() > 0 ? {18'h0, exp_pc.pop_front()} : 'x);
    if (cpu_out.wake === 1'b1)
      wake_cnt++;
  end

  initial begin
    idle(2);
    reset_n <= 1'b1;
    idle(3);
    for (int a = 0; a <= 9; a++) rd(6'(a * 4), 8'h00);
    for (int g = 0; g < 4; g++) begin
      r = 8'(rnd());
      wr(OFS_GRP0 + 6'(g * 4), r);
      rd(OFS_GRP0 + 6'(g * 4), r & MASK_GRP[g]);
      wr(OFS_GRP0 + 6'(g * 4), 8'h00);
    end
    wr(OFS_CTRL0, 8'h00);
    wr(OFS_CTRL1, 8'h00);
    wr(OFS_CTRL2, 8'h00);
    // pin 0 takes each edge code, pin 1 stays disabled
    for (int c = 0; c < 4; c++) begin
      wr(OFS_EDGE, 8'(c));
      wr(OFS_CTRL0, 8'h02);
      ext_irq_pin <= 2'b11;
      idle(4);
      rd(OFS_CTRL0, c[0] ? 8'h12 : 8'h02);
      wr(OFS_CTRL0, 8'h02);
      ext_irq_pin <= 2'b00;
      idle(4);
      rd(OFS_CTRL0, c[1] ? 8'h12 : 8'h02);
    end
    exp_pc.push_back(vec(0));
    wr(OFS_CTRL0, 8'h13);
    rd(OFS_CTRL0, 8'h02);
    exp_pc.push_back({1'b0, 13'h0100});
    ret_pulse();
    wr(OFS_CTRL0, 8'h01);
    w0 = wake_cnt;
    evt({1'b1, 16'h0});
    evt({1'b1, 16'h0});
    check(32'(wake_cnt - w0), 32'h1);
    rd(OFS_CTRL1, 8'h10);
    wr(OFS_CTRL0, 8'h00);
    wr(OFS_CTRL1, 8'h11);
    idle(4);
    rd(OFS_CTRL1, 8'h11);
    exp_pc.push_back(vec(2));
    wr(OFS_CTRL0, 8'h01);
    rd(OFS_CTRL1, 8'h01);
    rd(OFS_CTRL0, 8'h00);
    wr(OFS_CTRL0, 8'h01);
    exp_pc.push_back(vec(2));
    evt({1'b1, 16'h0});
    wr(OFS_CTRL0, 8'h01);
    evt({1'b1, 16'h0});
    rd(OFS_STACK, 8'h82);
    check({31'h0, cpu_out.stack_full}, 32'h1);
    rd(OFS_CTRL1, 8'h11);
    exp_pc.push_back({1'b0, 13'h000C});
    exp_pc.push_back(vec(2));
    ret_pulse();
    exp_pc.push_back({1'b0, 13'h000C});
    exp_pc.push_back({1'b0, 13'h0100});
    ret_pulse();
    ret_pulse();
    wr(OFS_CTRL1, 8'h00);
    slow <= 1'b1;
    for (int g = 0; g < 4; g++) begin
      wr(OFS_GRP0 + 6'(g * 4), 8'h01);
      evt({1'b0, 16'(2 << (g * 4))});
      exp_pc.push_back(vec(3 + g));
      wr(GA[g], GV[g]);
      wr(OFS_CTRL0, g == 0 ? 8'h09 : 8'h01);
      evt({1'b0, 16'(1 << (g * 4))});
      idle(4);
      rd(OFS_GRP0 + 6'(g * 4), 8'h31);
      rd(GA[g], GV[g]);
      wr(OFS_GRP0 + 6'(g * 4), 8'h00);
      exp_pc.push_back({1'b0, 13'h0100});
      ret_pulse();
      wr(GA[g], 8'h00);
    end
    idle(4);
    check(32'(exp_pc.size() + exp_rd.size()), 32'h0);
    final_report();
  end

  initial begin
    idle(20000);
    error_cnt++;
    final_report();
  end
endmodule // vic_top_tb
